// *** hw/adc_cfg_pkg.sv ***
// Package with register map, field layout, reset values and carrier types of the converter configuration port.
package adc_cfg_pkg;
    // --------------------------------------------------------------------
    // Register select codes on the two upper bus lines
    // --------------------------------------------------------------------
    localparam logic [1:0] SEL_CLAMP_CODE_LOW = 2'h0;
    localparam logic [1:0] SEL_CLAMP_CODE_HIGH = 2'h1;
    localparam logic [1:0] SEL_CONVERTER_CONTROL = 2'h2;
    localparam logic [1:0] SEL_RESERVED_LOCATION = 2'h3;
    // --------------------------------------------------------------------
    // Bus layout and field positions
    // --------------------------------------------------------------------
    localparam int BUS_W = 10;
    localparam int SEL_LSB = 8;
    localparam int GAIN_LSB = 0;
    localparam int GAIN_MSB = 2;
    localparam int POWER_OFF_BIT = 3;
    localparam int CLAMP_SOURCE_BIT = 4;
    localparam int SIGNED_FORMAT_BIT = 5;
    localparam int BIAS_DISABLE_BIT = 6;
    localparam logic [7:0] HIGH_USED_MASK = 8'h03;
    localparam logic [7:0] CONTROL_USED_MASK = 8'h7F;
    localparam logic [9:0] SIGN_FLIP = 10'h200;
    // --------------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------------
    localparam logic [7:0] CLAMP_CODE_LOW_RST = 8'h00;
    localparam logic [7:0] CLAMP_CODE_HIGH_RST = 8'h00;
    localparam logic [7:0] CONVERTER_CONTROL_RST = 8'h01;
    // --------------------------------------------------------------------
    // Carrier types
    // --------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] gain_code;
        logic power_off_request;
        logic clamp_source_select;
        logic signed_format_select;
        logic bias_output_disable;
        logic [9:0] clamp_code;
    } cfg_t;

    typedef struct packed {
        logic [9:0] data;
        logic range_flag;
    } sample_t;
endpackage

// *** hw/output_driver.sv ***
// Output stage that formats a conversion result and drives the shared bus.
`timescale 1ns/1ps
module output_driver (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic out_disable_i,
    input wire logic signed_format_i,
    input wire adc_cfg_pkg::sample_t sample_i,
    output logic [9:0] bus_o,
    output logic bus_oe_o,
    output logic range_flag_o,
    output logic range_flag_oe_o
);
    typedef struct packed {
        logic [9:0] bus;
        logic range_flag;
    } drv_state_t;

    drv_state_t state_ff;
    drv_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        // Two's complement of an offset-binary result is the MSB inverted.
        nxt_state.bus = signed_format_i ? (sample_i.data ^ adc_cfg_pkg::SIGN_FLIP) : sample_i.data;
        nxt_state.range_flag = sample_i.range_flag;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus_o = state_ff.bus;
    assign range_flag_o = state_ff.range_flag;
    // Enables follow the pin directly so the bus turns round without a cycle of contention.
    assign bus_oe_o = ~out_disable_i;
    assign range_flag_oe_o = ~out_disable_i;

    property p_oe_follows;
        @(posedge clk_sys_i) disable iff (rst_i) bus_oe_o == !out_disable_i && range_flag_oe_o == bus_oe_o;
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("output enable does not follow disable pin");

    property p_format;
        @(posedge clk_sys_i) disable iff (rst_i)
            1'b1 |=> bus_o == ($past(signed_format_i) ? ($past(sample_i.data) ^ adc_cfg_pkg::SIGN_FLIP)
            : $past(sample_i.data));
    endproperty
    a_format: assert property (p_format) else $error("output data format wrong");
endmodule

// *** hw/adc_config_register_port.sv ***
// Configuration register bank and clamp control of the 10-bit video converter.
`timescale 1ns/1ps
module adc_config_register_port (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic out_disable_i,
    input wire logic write_strobe_i,
    input wire logic [9:0] bus_i,
    output logic [9:0] bus_o,
    output logic bus_oe_o,
    output logic range_flag_o,
    output logic range_flag_oe_o,
    input wire logic clamp_i,
    input wire adc_cfg_pkg::sample_t sample_i,
    output adc_cfg_pkg::cfg_t cfg_o,
    output logic clamp_engage_o,
    output logic clamp_from_dac_o,
    output logic bias_output_pin_enable_o
);
    // --------------------------------------------------------------------
    // State
    // --------------------------------------------------------------------
    typedef struct packed {
        logic strobe_d;
        logic [9:0] bus_d;
        logic [7:0] clamp_code_low;
        logic [7:0] clamp_code_high;
        logic [7:0] converter_control;
        logic clamp_engage;
    } port_state_t;

    port_state_t state_ff;
    port_state_t nxt_state;

    function automatic logic is_select(input logic [9:0] bus, input logic [1:0] sel);
        is_select = bus[9:adc_cfg_pkg::SEL_LSB] == sel;
    endfunction

    // --------------------------------------------------------------------
    // Write decode
    // --------------------------------------------------------------------
    // Data is latched on the falling edge of the strobe, using the bus value
    // seen while the strobe was still high, so the host may change the bus
    // in the same cycle it drops the strobe.
    logic write_fire;
    assign write_fire = state_ff.strobe_d && !write_strobe_i && out_disable_i;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.strobe_d = write_strobe_i;
        if (write_strobe_i) begin
            nxt_state.bus_d = bus_i;
        end
        if (write_fire) begin
            if (is_select(state_ff.bus_d, adc_cfg_pkg::SEL_CLAMP_CODE_LOW)) begin
                nxt_state.clamp_code_low = state_ff.bus_d[7:0];
            end else if (is_select(state_ff.bus_d, adc_cfg_pkg::SEL_CLAMP_CODE_HIGH)) begin
                nxt_state.clamp_code_high = state_ff.bus_d[7:0] & adc_cfg_pkg::HIGH_USED_MASK;
            end else if (is_select(state_ff.bus_d, adc_cfg_pkg::SEL_CONVERTER_CONTROL)) begin
                nxt_state.converter_control = state_ff.bus_d[7:0] & adc_cfg_pkg::CONTROL_USED_MASK;
            end
            // The reserved location takes nothing; a stray write there is dropped.
        end
        nxt_state.clamp_engage = clamp_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff.strobe_d <= 1'b0;
            state_ff.bus_d <= '0;
            state_ff.clamp_code_low <= adc_cfg_pkg::CLAMP_CODE_LOW_RST;
            state_ff.clamp_code_high <= adc_cfg_pkg::CLAMP_CODE_HIGH_RST;
            state_ff.converter_control <= adc_cfg_pkg::CONVERTER_CONTROL_RST;
            state_ff.clamp_engage <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // --------------------------------------------------------------------
    // Configuration outputs
    // --------------------------------------------------------------------
    always_comb begin
        cfg_o.gain_code = state_ff.converter_control[adc_cfg_pkg::GAIN_MSB:adc_cfg_pkg::GAIN_LSB];
        cfg_o.power_off_request = state_ff.converter_control[adc_cfg_pkg::POWER_OFF_BIT];
        cfg_o.clamp_source_select = state_ff.converter_control[adc_cfg_pkg::CLAMP_SOURCE_BIT];
        cfg_o.signed_format_select = state_ff.converter_control[adc_cfg_pkg::SIGNED_FORMAT_BIT];
        cfg_o.bias_output_disable = state_ff.converter_control[adc_cfg_pkg::BIAS_DISABLE_BIT];
        cfg_o.clamp_code = {state_ff.clamp_code_high[1:0], state_ff.clamp_code_low};
    end

    assign clamp_engage_o = state_ff.clamp_engage;
    assign clamp_from_dac_o = cfg_o.clamp_source_select;
    assign bias_output_pin_enable_o = ~cfg_o.bias_output_disable;

    // --------------------------------------------------------------------
    // Output stage
    // --------------------------------------------------------------------
    output_driver output_driver_i (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .out_disable_i(out_disable_i),
        .signed_format_i(cfg_o.signed_format_select),
        .sample_i(sample_i),
        .bus_o(bus_o),
        .bus_oe_o(bus_oe_o),
        .range_flag_o(range_flag_o),
        .range_flag_oe_o(range_flag_oe_o)
    );

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    // The keep and field checks decode each write once more, through the same select function,
    // so that each of those properties names the location that it guards.
    logic fire_low;
    logic fire_high;
    logic fire_ctrl;
    assign fire_low = write_fire && is_select(state_ff.bus_d, adc_cfg_pkg::SEL_CLAMP_CODE_LOW);
    assign fire_high = write_fire && is_select(state_ff.bus_d, adc_cfg_pkg::SEL_CLAMP_CODE_HIGH);
    assign fire_ctrl = write_fire && is_select(state_ff.bus_d, adc_cfg_pkg::SEL_CONVERTER_CONTROL);

    // The strobe history and the captured bus are what a write at the falling
    // edge relies on; if either slips, writes land with the wrong word.
    property p_strobe_track;
        @(posedge clk_sys_i) disable iff (rst_i) 1'b1 |=> state_ff.strobe_d == $past(write_strobe_i);
    endproperty
    a_strobe_track: assert property (p_strobe_track) else $error("strobe history lost");

    property p_capture;
        @(posedge clk_sys_i) disable iff (rst_i) write_strobe_i |=> state_ff.bus_d == $past(bus_i);
    endproperty
    a_capture: assert property (p_capture) else $error("bus not captured while strobe high");

    property p_refused_driving;
        @(posedge clk_sys_i) disable iff (rst_i)
            state_ff.strobe_d && !write_strobe_i && !out_disable_i |=> $stable(cfg_o);
    endproperty
    a_refused_driving: assert property (p_refused_driving) else $error("write taken while bus driven");

    // --------------------------------------------------------------------
    // Clamp code checks
    // --------------------------------------------------------------------
    property p_low_write;
        @(posedge clk_sys_i) disable iff (rst_i)
            write_fire && state_ff.bus_d[9:8] == 2'b00 |=> cfg_o.clamp_code[7:0] == $past(state_ff.bus_d[7:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low clamp write lost");

    property p_low_keeps_high;
        @(posedge clk_sys_i) disable iff (rst_i) fire_low |=> $stable(cfg_o.clamp_code[9:8]);
    endproperty
    a_low_keeps_high: assert property (p_low_keeps_high) else $error("low clamp write touched high bits");

    property p_high_write;
        @(posedge clk_sys_i) disable iff (rst_i)
            write_fire && state_ff.bus_d[9:8] == 2'b01 |=> cfg_o.clamp_code[9:8] == $past(state_ff.bus_d[1:0])
            && state_ff.clamp_code_high[7:2] == 6'h00;
    endproperty
    a_high_write: assert property (p_high_write) else $error("high clamp write wrong");

    property p_high_keeps_low;
        @(posedge clk_sys_i) disable iff (rst_i) fire_high |=> $stable(cfg_o.clamp_code[7:0]);
    endproperty
    a_high_keeps_low: assert property (p_high_keeps_low) else $error("high clamp write touched low bits");

    property p_clamp_keeps_ctrl;
        @(posedge clk_sys_i) disable iff (rst_i) fire_low || fire_high |=> $stable(state_ff.converter_control);
    endproperty
    a_clamp_keeps_ctrl: assert property (p_clamp_keeps_ctrl) else $error("clamp write touched control");

    // --------------------------------------------------------------------
    // Control register, reserved location, reset and clamp pin checks
    // --------------------------------------------------------------------
    // Each field is checked on its own, so a slip of one bit position names
    // the field that moved rather than the whole word.

    property p_ctrl_write;
        @(posedge clk_sys_i) disable iff (rst_i)
            write_fire && state_ff.bus_d[9:8] == 2'b10
            |=> state_ff.converter_control == {1'b0, $past(state_ff.bus_d[6:0])};
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");

    property p_gain_write;
        @(posedge clk_sys_i) disable iff (rst_i)
            fire_ctrl |=> cfg_o.gain_code == $past(state_ff.bus_d[adc_cfg_pkg::GAIN_MSB:adc_cfg_pkg::GAIN_LSB]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain code not taken");

    property p_power_write;
        @(posedge clk_sys_i) disable iff (rst_i)
            fire_ctrl |=> cfg_o.power_off_request == $past(state_ff.bus_d[adc_cfg_pkg::POWER_OFF_BIT]);
    endproperty
    a_power_write: assert property (p_power_write) else $error("power-down request not taken");

    property p_source_write;
        @(posedge clk_sys_i) disable iff (rst_i)
            fire_ctrl |=> cfg_o.clamp_source_select == $past(state_ff.bus_d[adc_cfg_pkg::CLAMP_SOURCE_BIT]);
    endproperty
    a_source_write: assert property (p_source_write) else $error("clamp source select not taken");

    property p_format_write;
        @(posedge clk_sys_i) disable iff (rst_i)
            fire_ctrl |=> cfg_o.signed_format_select == $past(state_ff.bus_d[adc_cfg_pkg::SIGNED_FORMAT_BIT]);
    endproperty
    a_format_write: assert property (p_format_write) else $error("output format select not taken");

    property p_bias_write;
        @(posedge clk_sys_i) disable iff (rst_i)
            fire_ctrl |=> cfg_o.bias_output_disable == $past(state_ff.bus_d[adc_cfg_pkg::BIAS_DISABLE_BIT]);
    endproperty
    a_bias_write: assert property (p_bias_write) else $error("bias disable not taken");

    property p_ctrl_keeps_clamp;
        @(posedge clk_sys_i) disable iff (rst_i) fire_ctrl |=> $stable(cfg_o.clamp_code);
    endproperty
    a_ctrl_keeps_clamp: assert property (p_ctrl_keeps_clamp) else $error("control write touched clamp code");

    property p_reserved;
        @(posedge clk_sys_i) disable iff (rst_i)
            write_fire && state_ff.bus_d[9:8] == 2'b11 |=> $stable(cfg_o);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved write changed registers");

    property p_no_write_stable;
        @(posedge clk_sys_i) disable iff (rst_i) !write_fire |=> $stable(cfg_o);
    endproperty
    a_no_write_stable: assert property (p_no_write_stable) else $error("registers changed without write");

    property p_reset_value;
        @(posedge clk_sys_i) $fell(rst_i) |-> cfg_o.gain_code == 3'h1 && !cfg_o.power_off_request
            && !cfg_o.clamp_source_select && !cfg_o.signed_format_select && !cfg_o.bias_output_disable
            && cfg_o.clamp_code == 10'h000;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("wrong value after reset");

    // The hold check runs while reset is still high, so a field that misses
    // its reset branch is caught before the first write.
    property p_reset_hold;
        @(posedge clk_sys_i) rst_i |=> state_ff.converter_control == adc_cfg_pkg::CONVERTER_CONTROL_RST
            && state_ff.clamp_code_low == adc_cfg_pkg::CLAMP_CODE_LOW_RST
            && state_ff.clamp_code_high == adc_cfg_pkg::CLAMP_CODE_HIGH_RST && !clamp_engage_o;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("register left its reset value during reset");

    property p_unused_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
            state_ff.clamp_code_high[7:2] == 6'h00 && !state_ff.converter_control[7];
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused register bit set");

    property p_clamp;
        @(posedge clk_sys_i) disable iff (rst_i) clamp_i |=> clamp_engage_o;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp not engaged");

    property p_unclamp;
        @(posedge clk_sys_i) disable iff (rst_i) !clamp_i |=> !clamp_engage_o;
    endproperty
    a_unclamp: assert property (p_unclamp) else $error("clamp not released");

    property p_bias;
        @(posedge clk_sys_i) disable iff (rst_i)
            bias_output_pin_enable_o != state_ff.converter_control[adc_cfg_pkg::BIAS_DISABLE_BIT]
            && clamp_from_dac_o == state_ff.converter_control[adc_cfg_pkg::CLAMP_SOURCE_BIT];
    endproperty
    a_bias: assert property (p_bias) else $error("bias or source select mismatch");

    // --------------------------------------------------------------------
    // Output stage checks
    // --------------------------------------------------------------------
    // The enables are combinational, so they are checked against the pin in
    // the same cycle; a one-cycle lag would mean bus contention on turn-round.
    property p_drivers_off;
        @(posedge clk_sys_i) disable iff (rst_i) out_disable_i |-> !bus_oe_o && !range_flag_oe_o;
    endproperty
    a_drivers_off: assert property (p_drivers_off) else $error("drivers on while output disabled");

    property p_drivers_on;
        @(posedge clk_sys_i) disable iff (rst_i) !out_disable_i |-> bus_oe_o && range_flag_oe_o;
    endproperty
    a_drivers_on: assert property (p_drivers_on) else $error("drivers off while output enabled");

    property p_range_flag;
        @(posedge clk_sys_i) disable iff (rst_i) 1'b1 |=> range_flag_o == $past(sample_i.range_flag);
    endproperty
    a_range_flag: assert property (p_range_flag) else $error("range flag not forwarded");
endmodule

// *** verification/host_model.sv ***
// Host controller model that writes configuration words over the shared bus.
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic hiz_i,
    input wire logic [9:0] word_i,
    input wire logic [1:0] hold_i,
    output logic out_disable_o,
    output logic write_strobe_o,
    output logic [9:0] bus_o,
    output logic done_o
);
    logic [1:0] cnt_ff;
    logic busy_ff;
    logic [9:0] last_ff;
    // ------------------------------------------------------------
    // Write cycle: bus held from strobe rise until strobe falls
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            busy_ff <= 1'b0;
            write_strobe_o <= 1'b0;
            last_ff <= 10'h000;
            cnt_ff <= 2'h0;
        end else if (req_i && !busy_ff) begin
            busy_ff <= 1'b1;
            write_strobe_o <= 1'b1;
            last_ff <= word_i;
            cnt_ff <= hold_i;
        end else if (write_strobe_o) begin
            if (cnt_ff == 2'h0) write_strobe_o <= 1'b0;
            else cnt_ff <= cnt_ff - 2'h1;
        end else if (busy_ff) begin
            busy_ff <= 1'b0;
            done_o <= 1'b1;
        end
    end
    // Output disable stays high over the whole cycle so the fall is seen as a write.
    assign out_disable_o = busy_ff | hiz_i;
    // A released bus shows the inverse of the last word, never a stale copy.
    assign bus_o = write_strobe_o ? last_ff : ~last_ff;
endmodule

// *** verification/test_adc_config_register_port.sv ***
// Self-checking testbench of the converter configuration port.
`timescale 1ns/1ps
module test_adc_config_register_port;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic req = 1'b0, hiz = 1'b1, clamp = 1'b0, done, od, stb;
    logic [1:0] hold = 2'h0;
    logic [9:0] word = 10'h000, hbus, dbus, bus;
    logic doe, rf, rfoe, eng, dac, bias;
    adc_cfg_pkg::sample_t smp = '0;
    adc_cfg_pkg::cfg_t cfg;
    logic [7:0] lo = 8'h00, hi = 8'h00, ct = 8'h01;
    logic [31:0] seed = 32'h45;
    int fail_count = 0, cmp_count = 0;
    assign bus = od ? hbus : dbus;
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    host_model host_model_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .hiz_i(hiz), .word_i(word),
        .hold_i(hold), .out_disable_o(od), .write_strobe_o(stb), .bus_o(hbus), .done_o(done));
    adc_config_register_port adc_config_register_port_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .out_disable_i(od), .write_strobe_i(stb), .bus_i(bus), .bus_o(dbus), .bus_oe_o(doe),
        .range_flag_o(rf), .range_flag_oe_o(rfoe), .clamp_i(clamp), .sample_i(smp), .cfg_o(cfg),
        .clamp_engage_o(eng), .clamp_from_dac_o(dac), .bias_output_pin_enable_o(bias));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic adc_cfg_pkg::cfg_t exp_cfg();
        return {ct[2:0], ct[3], ct[4], ct[5], ct[6], hi[1:0], lo};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One full write; the register is updated on the same edge at which the host reports done.
    task automatic wr(input logic [9:0] w);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        req <= 1'b1;
        word <= w;
        hold <= seed[1:0];
        @(posedge clk_sys_i);
        req <= 1'b0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        if (n >= 20) begin
            fail_count++;
            end_of_test();
        end
        case (w[9:8])
            adc_cfg_pkg::SEL_CLAMP_CODE_LOW: lo = w[7:0];
            adc_cfg_pkg::SEL_CLAMP_CODE_HIGH: hi = w[7:0] & adc_cfg_pkg::HIGH_USED_MASK;
            adc_cfg_pkg::SEL_CONVERTER_CONTROL: ct = w[7:0] & adc_cfg_pkg::CONTROL_USED_MASK;
            default: ;
        endcase
        @(posedge clk_sys_i);
        #1;
        chk(cfg, exp_cfg());
        chk(dac, ct[4]);
        chk(bias, !ct[6]);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [1:0] sel;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk(cfg, exp_cfg());
        chk(bias, 1'b1);
        for (int i = 0; i < 40; i++) begin
            r = xs();
            // Random selects stay off the reserved location.
            sel = (i < 8) ? 2'h2 : 2'(r[31:8] % 3);
            if (i < 8) r[2:0] = 3'(i);
            wr({sel, r[7:0]});
        end
        wr({adc_cfg_pkg::SEL_RESERVED_LOCATION, 8'hFF});
        for (int i = 0; i < 24; i++) begin
            r = xs();
            if (i == 12) wr({adc_cfg_pkg::SEL_CONVERTER_CONTROL, ct ^ 8'h20});
            @(posedge clk_sys_i);
            hiz <= 1'b0;
            smp <= r[10:0];
            clamp <= r[20];
            @(posedge clk_sys_i);
            #1;
            chk(dbus, smp.data ^ {ct[5], 9'h000});
            chk(rf, smp.range_flag);
            chk({doe, rfoe}, 2'h3);
            chk(eng, clamp);
        end
        @(posedge clk_sys_i);
        hiz <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk({doe, rfoe}, 2'h0);
        end_of_test();
    end
endmodule
